//--- rtl/epo_encoder_objects.sv
// Encoder profile objects, position PDO bytes, status log and diagnostics recorder
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"
// Contract
// R1: Bit 3 sets counting direction, reset zero
// R2: Only direction bit affects behaviour
// R3: Read-only status mirrors operating parameter
// R4: Signed position clamped, mapped to both PDOs
// R5: Position bytes sent least significant first
// R6: Increment reported in nanometre units
// R7: 25-entry ring log overwrites oldest
// R8: Messages logged automatically, no enable
// R9: Log empty after power-up
// R10: Entry holds type class and number
// R11: Occurrence count always one
// R12: Acknowledge or delete one or all
// R13: Escape stops diagnostics and clears recording
// R14: Diagnostics never disturb bus answers
module epo_encoder_objects #(
    parameter int DIAG_DEPTH = 8
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire epo_pkg::epo_sdo_req_t sdo_req,
    output logic                    sdo_ack,
    output logic                    sdo_err,
    output logic [31:0]             sdo_rdata,
    input  wire logic signed [31:0] raw_pos,
    input  wire logic [31:0]        resolution_um,
    input  wire logic               pdo_trig,
    output logic [7:0]              pdo_byte,
    output logic                    pdo_byte_valid,
    output logic                    pdo_sel,
    output logic                    pdo_last,
    input  wire logic               ev_valid,
    input  wire epo_pkg::epo_mtype_t ev_type,
    input  wire logic [7:0]         ev_num,
    input  wire logic               diag_start,
    input  wire logic               diag_esc,
    output logic                    diag_active,
    output logic [3:0]              diag_level
);
    logic [15:0]        oppar_q;
    logic [15:0]        opstat_q;
    logic [31:0]        incr_q;
    logic signed [31:0] pos;
    logic [31:0]        pdo_sh_q;
    logic [1:0]         pdo_cnt_q;
    logic               pdo_tpdo_q;
    epo_pkg::epo_tx_t   tx_q;
    epo_pkg::epo_act_t  act_q;
    logic [4:0]         act_pos_q;
    logic [4:0]         rd_pos_q;
    epo_pkg::epo_entry_t log_e;
    logic               log_v;
    logic [4:0]         log_n;
    logic [7:0]         diag_mem_q [DIAG_DEPTH];
    logic [3:0]         diag_wp_q;

    wire logic rd  = sdo_req.req && !sdo_req.wr;
    wire logic wr  = sdo_req.req && sdo_req.wr;
    wire logic hit_oppar  = sdo_req.idx == `EPO_IDX_OPPAR;
    wire logic hit_pos    = sdo_req.idx == `EPO_IDX_POS;
    wire logic hit_opstat = sdo_req.idx == `EPO_IDX_OPSTAT;
    wire logic hit_incr   = sdo_req.idx == `EPO_IDX_INCR;
    wire logic hit_lstat  = sdo_req.idx == `EPO_IDX_LOGSTAT;
    wire logic hit_lrd    = sdo_req.idx == `EPO_IDX_LOGRD;
    wire logic hit_lact   = sdo_req.idx == `EPO_IDX_LOGACT;
    wire logic hit_diag   = sdo_req.idx == `EPO_IDX_DIAG;
    // Writes are legal only to the operating parameter and the two log controls
    wire logic wr_ok  = hit_oppar || hit_lact || hit_lrd;
    wire logic rd_ok  = hit_oppar || hit_pos || hit_opstat || hit_incr
                        || hit_lstat || hit_lrd || hit_diag;
    wire logic dir_neg = oppar_q[`EPO_DIR_BIT];
    // Only bit 3 is stored; unused and reserved bits read zero
    wire logic [15:0] oppar_w = {12'h000, sdo_req.wdata[`EPO_DIR_BIT], 3'h0}; // R2
    wire logic [31:0] incr_nm = 32'(resolution_um * 32'h0000_03E8); // R6
    wire logic [31:0] rdata_mux =
        hit_oppar  ? {16'h0000, oppar_q} :
        hit_pos    ? pos :
        hit_opstat ? {16'h0000, opstat_q} :
        hit_incr   ? incr_q :
        hit_lstat  ? {27'h000_0000, log_n} :
        hit_lrd    ? {8'h00, log_v, 4'h0, log_e} :
        hit_diag   ? {27'h000_0000, diag_active, diag_wp_q} : 32'h0000_0000;

    epo_pos_shaper u_shape (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .raw     (raw_pos),
        .dir_neg (dir_neg),
        .pos     (pos)
    );

    epo_status_log #(.DEPTH(`EPO_LOG_DEPTH)) u_log (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .ev_valid (ev_valid), // R8
        .ev_type  (ev_type),
        .ev_num   (ev_num),
        .act      (act_q),
        .act_pos  (act_pos_q),
        .rd_pos   (rd_pos_q),
        .rd_entry (log_e),
        .rd_valid (log_v),
        .count    (log_n)
    );

    // Object dictionary access, one-cycle answer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            oppar_q   <= `EPO_OPPAR_RST; // R1
            opstat_q  <= `EPO_OPPAR_RST;
            incr_q    <= 32'h0000_0000;
            sdo_ack   <= 1'b0;
            sdo_err   <= 1'b0;
            sdo_rdata <= 32'h0000_0000;
            act_q     <= epo_pkg::EPO_ACT_NONE;
            act_pos_q <= 5'd0;
            rd_pos_q  <= 5'd0;
        end else if (ce) begin
            opstat_q  <= oppar_q; // R3
            incr_q    <= incr_nm; // R6
            sdo_ack   <= sdo_req.req;
            sdo_err   <= (wr && !wr_ok) || (rd && !rd_ok);
            sdo_rdata <= rd ? rdata_mux : 32'h0000_0000;
            act_q     <= epo_pkg::EPO_ACT_NONE;
            if (wr && hit_oppar) oppar_q <= oppar_w; // R1 R2
            if (wr && hit_lrd) rd_pos_q <= sdo_req.wdata[4:0];
            if (wr && hit_lact) begin
                act_q     <= epo_pkg::epo_act_t'(sdo_req.wdata[10:8]); // R12
                act_pos_q <= sdo_req.wdata[4:0];
            end
        end
    end

    // Transmit PDO byte stream, TPDO1 then TPDO2 share the value
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_q           <= epo_pkg::EPO_TX_IDLE;
            pdo_sh_q       <= 32'h0000_0000;
            pdo_cnt_q      <= 2'd0;
            pdo_tpdo_q     <= 1'b0;
            pdo_byte       <= 8'h00;
            pdo_byte_valid <= 1'b0;
            pdo_sel        <= 1'b0;
            pdo_last       <= 1'b0;
        end else if (ce) begin
            pdo_byte_valid <= 1'b0;
            pdo_last       <= 1'b0;
            case (tx_q)
                epo_pkg::EPO_TX_IDLE: begin
                    if (pdo_trig) begin
                        tx_q       <= epo_pkg::EPO_TX_SEND;
                        pdo_sh_q   <= pos; // R4
                        pdo_cnt_q  <= 2'd0;
                        pdo_tpdo_q <= 1'b0;
                    end
                end
                epo_pkg::EPO_TX_SEND: begin
                    pdo_byte       <= pdo_sh_q[8*pdo_cnt_q +: 8]; // R5
                    pdo_byte_valid <= 1'b1;
                    pdo_sel        <= pdo_tpdo_q;
                    pdo_last       <= pdo_cnt_q == 2'd3;
                    pdo_cnt_q      <= pdo_cnt_q + 2'd1;
                    if (pdo_cnt_q == 2'd3) begin
                        pdo_tpdo_q <= 1'b1;
                        if (pdo_tpdo_q) tx_q <= epo_pkg::EPO_TX_IDLE; // R4
                    end
                end
                default: tx_q <= epo_pkg::EPO_TX_IDLE;
            endcase
        end
    end

    // Recorder taps the incoming log events only; it has no path into the SDO answer timing
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            diag_active <= 1'b0;
            diag_wp_q   <= 4'd0;
            diag_level  <= 4'h0;
        end else if (ce) begin
            if (diag_esc) begin
                diag_active <= 1'b0; // R13
                diag_wp_q   <= 4'd0;
                diag_level  <= 4'h0;
            end else begin
                if (diag_start) diag_active <= 1'b1; // R14
                if (diag_active && ev_valid && diag_wp_q != 4'(DIAG_DEPTH)) begin
                    diag_wp_q  <= diag_wp_q + 4'd1;
                    diag_level <= diag_wp_q + 4'd1;
                end
            end
        end
    end

    genvar d;
    generate
        for (d = 0; d < DIAG_DEPTH; d++) begin : g_diag
            always_ff @(posedge mclk) begin
                if (!rst_n) diag_mem_q[d] <= 8'h00;
                else if (ce && diag_esc) diag_mem_q[d] <= 8'h00; // R13
                else if (ce && diag_active && ev_valid && diag_wp_q == 4'(d))
                    diag_mem_q[d] <= ev_num;
            end
        end
    endgenerate

    a_mirror: assert property (@(posedge mclk) disable iff (!rst_n) // R3
        ce && $stable(oppar_q) |=> opstat_q == $past(oppar_q))
        else $error("status mirror lags");
    a_resv: assert property (@(posedge mclk) disable iff (!rst_n) // R2
        (oppar_q & 16'hFFF7) == 16'h0000) else $error("reserved bits stored");
    a_esc: assert property (@(posedge mclk) disable iff (!rst_n) // R13
        ce && diag_esc |=> !diag_active && diag_wp_q == 4'd0 && diag_mem_q[0] == 8'h00)
        else $error("escape did not clear recorder");
    a_ack: assert property (@(posedge mclk) disable iff (!rst_n) // R14
        ce && sdo_req.req |=> sdo_ack) else $error("answer delayed");
    a_byte0: assert property (@(posedge mclk) disable iff (!rst_n) // R5
        ce && tx_q == epo_pkg::EPO_TX_IDLE && pdo_trig ##1 ce |=>
        pdo_byte == $past(pos[7:0], 2)) else $error("first byte not LSB");
    a_incr: assert property (@(posedge mclk) disable iff (!rst_n) // R6
        ce |=> incr_q == $past(incr_nm)) else $error("increment wrong");
endmodule
`default_nettype wire

//--- common/epo_regs.svh
// Object indexes, field positions, reset values and sizes for the encoder profile block
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH
`define EPO_IDX_OPPAR      16'h6000
`define EPO_IDX_POS        16'h6004
`define EPO_IDX_OPSTAT     16'h6500
`define EPO_IDX_INCR       16'h6501
`define EPO_IDX_LOGSTAT    16'h2100
`define EPO_IDX_LOGRD      16'h2101
`define EPO_IDX_LOGACT     16'h2102
`define EPO_IDX_DIAG       16'h2103
`define EPO_DIR_BIT        3
`define EPO_OPPAR_RST      16'h0000
`define EPO_POS_MAX        32'sd999999
`define EPO_POS_MIN        -32'sd999999
`define EPO_LOG_DEPTH      25
`define EPO_NM_PER_MM      32'h000F_4240
`define EPO_LOG_CNT        8'h01
`endif

//--- common/epo_pkg.sv
// Types shared by the encoder profile block
package epo_pkg;
    typedef enum logic [1:0] {
        EPO_INFO  = 2'h0,
        EPO_WARN  = 2'h1,
        EPO_ERROR = 2'h2,
        EPO_FATAL = 2'h3
    } epo_mtype_t;

    typedef struct packed {
        logic       ack;
        epo_mtype_t mtype;
        logic [7:0] num;
        logic [7:0] cnt;
    } epo_entry_t;

    typedef enum logic [2:0] {
        EPO_ACT_NONE    = 3'h0,
        EPO_ACT_ACK     = 3'h1,
        EPO_ACT_DEL     = 3'h2,
        EPO_ACT_ACK_ALL = 3'h3,
        EPO_ACT_DEL_ALL = 3'h4
    } epo_act_t;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] idx;
        logic [31:0] wdata;
    } epo_sdo_req_t;

    typedef enum logic [1:0] {
        EPO_TX_IDLE = 2'b00,
        EPO_TX_SEND = 2'b01
    } epo_tx_t;
endpackage

//--- rtl/epo_status_log.sv
// Ring memory of typed status messages
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"
module epo_status_log #(
    parameter int DEPTH = `EPO_LOG_DEPTH
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic               ev_valid,
    input  wire epo_pkg::epo_mtype_t ev_type,
    input  wire logic [7:0]         ev_num,
    input  wire epo_pkg::epo_act_t  act,
    input  wire logic [4:0]         act_pos,
    input  wire logic [4:0]         rd_pos,
    output var  epo_pkg::epo_entry_t rd_entry,
    output var  logic               rd_valid,
    output var  logic [4:0]         count
);
    epo_pkg::epo_entry_t mem_q [DEPTH];
    logic [DEPTH-1:0]    val_q;
    logic [4:0]          wp_q;
    logic [4:0]          wp_d;
    epo_pkg::epo_entry_t new_e;

    // Position n counts back from the newest entry
    function automatic logic [4:0] slot(input logic [4:0] wp, input logic [4:0] n);
        logic [5:0] s;
        s = {1'b0, wp} + 6'(DEPTH) - 6'd1 - {1'b0, n};
        if (s >= 6'(DEPTH)) s = s - 6'(DEPTH);
        return s[4:0];
    endfunction

    assign wp_d  = (wp_q == 5'(DEPTH - 1)) ? 5'd0 : wp_q + 5'd1;
    assign new_e = '{ack: 1'b0, mtype: ev_type, num: ev_num, cnt: `EPO_LOG_CNT}; // R10 R11

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_slot
            wire logic hit_a = (slot(wp_q, act_pos) == 5'(g));
            wire logic hit_w = ev_valid && (wp_q == 5'(g));
            // Power-up reset leaves the memory empty
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    val_q[g] <= 1'b0; // R9
                    mem_q[g] <= '0;
                end else if (ce) begin
                    // A new message wins over a delete in the same cycle
                    if (hit_w) begin
                        val_q[g] <= 1'b1; // R7 R8
                        mem_q[g] <= new_e;
                    end else if (act == epo_pkg::EPO_ACT_DEL_ALL ||
                                 (act == epo_pkg::EPO_ACT_DEL && hit_a)) begin
                        val_q[g] <= 1'b0; // R12
                    end else if (act == epo_pkg::EPO_ACT_ACK_ALL ||
                                 (act == epo_pkg::EPO_ACT_ACK && hit_a)) begin
                        mem_q[g].ack <= 1'b1; // R12
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wp_q     <= 5'd0;
            rd_entry <= '0;
            rd_valid <= 1'b0;
            count    <= 5'd0;
        end else if (ce) begin
            if (ev_valid) wp_q <= wp_d; // R7
            rd_entry <= mem_q[slot(wp_q, rd_pos)];
            rd_valid <= val_q[slot(wp_q, rd_pos)];
            count    <= 5'($countones(val_q));
        end
    end

    a_overwrite: assert property (@(posedge mclk) disable iff (!rst_n) // R7
        ce && ev_valid |=> val_q[$past(wp_q)] && mem_q[$past(wp_q)].cnt == 8'h01)
        else $error("log slot not written");
    a_cnt_le: assert property (@(posedge mclk) disable iff (!rst_n) // R7
        count <= 5'(DEPTH)) else $error("log count above depth");
endmodule
`default_nettype wire

//--- rtl/epo_pos_shaper.sv
// Orients, clamps and registers the position value
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"
module epo_pos_shaper (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic signed [31:0] raw,
    input  wire logic        dir_neg,
    output var  logic signed [31:0] pos
);
    logic signed [31:0] lim;
    logic signed [31:0] ori;

    assign ori = dir_neg ? -raw : raw; // R1
    assign lim = (ori > `EPO_POS_MAX) ? `EPO_POS_MAX :
                 (ori < `EPO_POS_MIN) ? `EPO_POS_MIN : ori; // R4

    always_ff @(posedge mclk) begin
        if (!rst_n) pos <= '0;
        else if (ce) pos <= lim;
    end

    a_range: assert property (@(posedge mclk) disable iff (!rst_n) // R4
        pos <= `EPO_POS_MAX && pos >= `EPO_POS_MIN) else $error("position out of range");
    a_dir: assert property (@(posedge mclk) disable iff (!rst_n) // R1
        ce && !dir_neg && raw >= 0 && raw <= `EPO_POS_MAX |=> pos == $past(raw))
        else $error("positive direction altered value");
endmodule
`default_nettype wire

//--- verification/epo_master_model.sv
// Bus master model that issues SDO transfers to the object dictionary
`timescale 1ns/1ps
`default_nettype none
module epo_master_model (
    input  wire logic                  mclk,
    output var  epo_pkg::epo_sdo_req_t sdo_req,
    input  wire logic                  sdo_ack,
    input  wire logic                  sdo_err,
    input  wire logic [31:0]           sdo_rdata
);
    initial sdo_req = '0;

    // Request is held until the answer shows, then dropped before the next edge
    // so the level-sampled request is never taken twice
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output int lat);
        lat = 0;
        @(negedge mclk);
        sdo_req <= '{req: 1'b1, wr: wr, idx: idx, wdata: wd};
        @(negedge mclk);
        while (sdo_ack !== 1'b1 && lat < 8) begin
            lat++;
            @(negedge mclk);
        end
        rd = sdo_rdata;
        err = sdo_err;
        sdo_req <= '0;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_encoder_profile_objects_status_log.sv
// Self-checking bench for the encoder profile objects block
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"
module tb_encoder_profile_objects_status_log;
    logic                  mclk, rst_n, trig, ev_v, d_start, d_esc;
    logic                  ack, err, pdo_v, pdo_sel, pdo_last, d_act;
    logic signed [31:0]    raw;
    logic [31:0]           res, rdata;
    logic [7:0]            pdo_byte, ev_num;
    logic [3:0]            d_lvl;
    epo_pkg::epo_mtype_t   ev_type;
    epo_pkg::epo_sdo_req_t req;
    int                    n_errors = 0;
    int                    compares = 0;

    epo_master_model m (.mclk(mclk), .sdo_req(req), .sdo_ack(ack), .sdo_err(err),
                        .sdo_rdata(rdata));
    epo_encoder_objects #(.DIAG_DEPTH(8)) dut (
        .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .sdo_req(req), .sdo_ack(ack),
        .sdo_err(err), .sdo_rdata(rdata), .raw_pos(raw), .resolution_um(res),
        .pdo_trig(trig), .pdo_byte(pdo_byte), .pdo_byte_valid(pdo_v), .pdo_sel(pdo_sel),
        .pdo_last(pdo_last), .ev_valid(ev_v), .ev_type(ev_type), .ev_num(ev_num),
        .diag_start(d_start), .diag_esc(d_esc), .diag_active(d_act), .diag_level(d_lvl));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Answer must come one cycle after the request, diagnostics running or not
    task automatic sdo(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [31:0] exp, input logic eerr);
        logic [31:0] r;
        logic        e;
        int          lat;
        m.xfer(wr, idx, wd, r, e, lat);
        chk(32'(lat), '0);
        chk(32'(e), 32'(eerr));
        if (!wr)
            chk(r, exp);
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    task automatic do_reset();
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
    endtask

    function automatic logic [31:0] ent(input int i, input logic a);
        return {8'h00, 1'b1, 4'h0, a, 2'(i % 4), 8'(i + 1), 8'h01};
    endfunction

    task automatic act(input epo_pkg::epo_act_t a, input int p);
        sdo(1'b1, `EPO_IDX_LOGACT, {21'h0, 3'(a), 3'h0, 5'(p)}, '0, 1'b0);
        repeat (3) @(negedge mclk);
    endtask

    task automatic pos_case(input logic [31:0] op, input int r, input int exp);
        sdo(1'b1, `EPO_IDX_OPPAR, op, '0, 1'b0);
        raw = r;
        sdo(1'b0, `EPO_IDX_POS, '0, 32'(exp), 1'b0);
    endtask

    task automatic t_reset();
        sdo(1'b0, `EPO_IDX_OPPAR, '0, '0, 1'b0);
        sdo(1'b0, `EPO_IDX_OPSTAT, '0, '0, 1'b0);
        sdo(1'b0, `EPO_IDX_LOGSTAT, '0, '0, 1'b0);
        $display("test reset values done");
    endtask

    task automatic t_dir();
        pos_case(32'h0000_FFF7, 1234, 1234);
        sdo(1'b0, `EPO_IDX_OPSTAT, '0, '0, 1'b0);
        pos_case(32'h0000_0008, 1234, -1234);
        sdo(1'b0, `EPO_IDX_OPSTAT, '0, 32'h0000_0008, 1'b0);
        pos_case(32'h0000_0008, -1000000, 999999);
        pos_case(32'h0000_0008, 999999, -999999);
        pos_case(32'h0000_0000, 1000000, 999999);
        pos_case(32'h0000_0000, -1000000, -999999);
        sdo(1'b1, `EPO_IDX_POS, 32'h0000_0001, '0, 1'b1);
        sdo(1'b0, 16'h1234, '0, '0, 1'b1);
        $display("test direction and clamp done");
    endtask

    task automatic t_incr();
        res = 32'h0000_03E8;
        sdo(1'b0, `EPO_IDX_INCR, '0, 32'h000F_4240, 1'b0);
        res = 32'h0000_0001;
        sdo(1'b0, `EPO_IDX_INCR, '0, 32'h0000_03E8, 1'b0);
        $display("test increment done");
    endtask

    task automatic t_pdo();
        int k;
        int n;
        k = 0;
        n = 0;
        raw = 32'sh000A_1B2C;
        repeat (3) @(negedge mclk);
        pulse(trig);
        while (k < 8 && n < 30) begin
            if (pdo_v === 1'b1) begin
                chk(32'(pdo_byte), 32'(raw[8*(k%4) +: 8]));
                chk(32'(pdo_sel), 32'(k / 4));
                chk(32'(pdo_last), 32'(k % 4 == 3));
                k++;
            end
            n++;
            @(negedge mclk);
        end
        chk(32'(k), 32'h0000_0008);
        $display("test position frames done");
    endtask

    task automatic t_log();
        logic [31:0] r;
        logic        e;
        int          lat;
        for (int i = 0; i < 27; i++) begin
            ev_type = epo_pkg::epo_mtype_t'(i % 4);
            ev_num = 8'(i + 1);
            pulse(ev_v);
        end
        repeat (2) @(negedge mclk);
        sdo(1'b0, `EPO_IDX_LOGSTAT, '0, 32'h0000_0019, 1'b0);
        for (int j = 0; j < 5; j++) begin
            sdo(1'b1, `EPO_IDX_LOGRD, (j == 4) ? 24 : j, '0, 1'b0);
            sdo(1'b0, `EPO_IDX_LOGRD, '0, ent((j == 4) ? 2 : 26 - j, 1'b0), 1'b0);
        end
        act(epo_pkg::EPO_ACT_ACK, 1);
        sdo(1'b1, `EPO_IDX_LOGRD, 32'h0000_0001, '0, 1'b0);
        sdo(1'b0, `EPO_IDX_LOGRD, '0, ent(25, 1'b1), 1'b0);
        act(epo_pkg::EPO_ACT_DEL, 0);
        sdo(1'b0, `EPO_IDX_LOGSTAT, '0, 32'h0000_0018, 1'b0);
        act(epo_pkg::EPO_ACT_ACK_ALL, 0);
        sdo(1'b1, `EPO_IDX_LOGRD, 32'h0000_0005, '0, 1'b0);
        m.xfer(1'b0, `EPO_IDX_LOGRD, '0, r, e, lat);
        chk(32'(r[18]), 32'h0000_0001);
        act(epo_pkg::EPO_ACT_DEL_ALL, 0);
        sdo(1'b0, `EPO_IDX_LOGSTAT, '0, '0, 1'b0);
        pulse(ev_v);
        do_reset();
        sdo(1'b0, `EPO_IDX_LOGSTAT, '0, '0, 1'b0);
        $display("test status log done");
    endtask

    task automatic t_diag();
        pulse(d_start);
        repeat (4) @(negedge mclk);
        chk(32'(d_act), 32'h0000_0001);
        pulse(ev_v);
        pulse(ev_v);
        chk(32'(d_lvl), 32'h0000_0002);
        sdo(1'b0, `EPO_IDX_DIAG, '0, 32'h0000_0012, 1'b0);
        sdo(1'b0, `EPO_IDX_INCR, '0, 32'h0000_03E8, 1'b0);
        pulse(d_esc);
        @(negedge mclk);
        chk(32'(d_act), '0);
        chk(32'(d_lvl), '0);
        sdo(1'b0, `EPO_IDX_DIAG, '0, '0, 1'b0);
        $display("test diagnostics done");
    endtask

    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        final_report();
    end

    initial begin
        {rst_n, trig, ev_v, d_start, d_esc, ev_num} = '0;
        ev_type = epo_pkg::EPO_INFO;
        raw = '0;
        res = 32'h0000_03E8;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_dir();
        t_incr();
        t_pdo();
        t_log();
        t_diag();
        final_report();
    end
endmodule
`default_nettype wire
